// >>> rtl/ifp_fetch_issue_unit.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Decode four, check resources for each
// R2 - Strict program order issue
// R3 - Advance group only when all issued
// R4 - Branch target mid-group issues to group end
// R5 - Refill buffer: four entries of 32 bytes
// R6 - Compare both ways; primary data forwarded
// R7 - Secondary hit delivers siloed data next cycle
// R8 - Double miss searches buffer, fills both
// R9 - One request per cycle until buffer committed
// R10 - Fill data kept until consumed or overwritten
// R11 - Prefetch only on true miss
// R12 - Adjacent fills go to same way
// R13 - Buffer fill on group need, one per cycle
// R14 - Miss enters fill mode, requests go out
// R15 - Hit in fill mode returns access, stops
// R16 - New PC returns access; outstanding fills accepted
// R17 - Four subblock valid bits per block
// R18 - Primary way is most recently hit
module ifp_fetch_issue_unit
(
   input  wire logic                   clock,
   input  wire logic                   rstn,
   input  wire logic                   redirect_valid,
   input  wire ifp_pkg::ifp_addr_t     redirect_pc,
   input  wire logic [3:0]             slot_ready,
   output logic [3:0]                  issue_mask,
   output ifp_pkg::ifp_group_t         issue_group,
   output logic                        mem_req_valid,
   input  wire logic                   mem_req_ready,
   output ifp_pkg::ifp_mem_req_t       mem_req,
   input  wire logic                   mem_resp_valid,
   input  wire ifp_pkg::ifp_mem_resp_t mem_resp,
   output logic                        fill_mode,
   output logic                        way_mispredict
);
   import ifp_pkg::*;

   function automatic ifp_laddr_t line_of(input ifp_addr_t a);
      line_of = a[IFP_ADDR_W-1:IFP_LINE_LSB];
   endfunction

   ifp_addr_t                pc;
   ifp_fetch_state_t         fstate;
   ifp_mode_t                mode;
   ifp_group_t               silo;
   logic                     silo_way;

   ifp_rb_state_t            rb_state [IFP_RB_ENTRIES];
   ifp_laddr_t               rb_line  [IFP_RB_ENTRIES];
   ifp_line_t                rb_data  [IFP_RB_ENTRIES];
   logic [1:0]               rb_used  [IFP_RB_ENTRIES];

   logic                     pf_active;
   logic [IFP_RB_ID_W-1:0]   pf_cnt;
   ifp_laddr_t               pf_base;

   logic [IFP_GADDR_W-1:0]   last_fill_grp;
   logic                     last_fill_way;
   logic                     last_fill_ok;

   logic [1:0]               hit;
   logic                     primary;
   ifp_group_t               rdata [2];
   logic                     need;

   logic                     want;
   logic                     prim_hit;
   logic                     sec_hit;
   logic                     take_prim;
   logic                     take_sec;
   logic                     take_rb;
   logic                     true_miss;
   logic                     grp_load;
   ifp_group_t               grp_data;
   logic [IFP_RB_ENTRIES-1:0] rb_full_hit;
   logic [IFP_RB_ENTRIES-1:0] rb_pend_hit;
   logic [IFP_RB_ID_W-1:0]   rb_sel;
   ifp_group_t               rb_group;
   logic                     fill_way;
   ifp_cwr_t                 cwr;
   logic                     req_fire;

   ifp_icache_ways u_ways
   (
      .clock     (clock),
      .rstn      (rstn),
      .rd_addr   (pc),
      .touch_en  (take_prim | take_sec),
      .touch_way (take_prim ? primary : ~primary),
      .wr_en     (take_rb),
      .wr        (cwr),
      .hit       (hit),
      .primary   (primary),
      .rdata     (rdata)
   );

   ifp_issue u_issue
   (
      .clock       (clock),
      .rstn        (rstn),
      .flush       (redirect_valid),
      .load        (grp_load),
      .load_group  (grp_data),
      .load_start  (pc[IFP_GRP_LSB-1:IFP_SLOT_LSB]),
      .slot_ready  (slot_ready),
      .need        (need),
      .issue_mask  (issue_mask),
      .issue_group (issue_group)
   );

   // Refill buffer search against the fetch line
   always_comb
   begin
      rb_sel = '0;
      for (int e = 0; e < IFP_RB_ENTRIES; e++)
      begin
         rb_full_hit[e] = (rb_state[e] == RB_FULL) && (rb_line[e] == line_of(pc));
         rb_pend_hit[e] = (rb_state[e] == RB_PEND) && (rb_line[e] == line_of(pc));
         if (rb_full_hit[e])
            rb_sel = IFP_RB_ID_W'(e);
      end
   end

   assign rb_group  = pc[IFP_GRP_LSB] ? rb_data[rb_sel][IFP_LINE_W-1:IFP_GROUP_W]
                                      : rb_data[rb_sel][IFP_GROUP_W-1:0];

   assign want      = need && (fstate == FS_LOOKUP) && !redirect_valid; // R13
   assign prim_hit  = primary ? hit[1] : hit[0];
   assign sec_hit   = primary ? hit[0] : hit[1];
   assign take_prim = want && prim_hit; // R6
   assign take_sec  = want && !prim_hit && sec_hit; // R7
   assign take_rb   = want && !(|hit) && (|rb_full_hit); // R8
   // A buffer hit or a fill still on its way is not a true miss
   assign true_miss = want && !(|hit) && !(|rb_full_hit) && !(|rb_pend_hit) && !pf_active; // R11

   assign grp_load  = take_prim || take_rb || (fstate == FS_SILO && !redirect_valid);
   assign grp_data  = take_prim ? rdata[primary] :
                      take_rb   ? rb_group : silo; // R7

   assign way_mispredict = (fstate == FS_SILO); // R7
   assign fill_mode      = (mode == MODE_FILL); // R14

   // Keep running fills in one way so sequential code stays way-predicted
   assign fill_way = (last_fill_ok && (last_fill_grp + 1'b1 == pc[IFP_ADDR_W-1:IFP_GRP_LSB]))
                     ? last_fill_way : ~primary; // R12

   always_comb
   begin
      cwr.way  = fill_way;
      cwr.idx  = pc[IFP_TAG_LSB-1:IFP_BLK_LSB];
      cwr.sub  = pc[IFP_BLK_LSB-1:IFP_GRP_LSB]; // R17
      cwr.tag  = pc[IFP_ADDR_W-1:IFP_TAG_LSB];
      cwr.data = rb_group; // R8
   end

   assign mem_req_valid = pf_active && (mode == MODE_FILL) && !redirect_valid; // R14
   assign mem_req.id    = pf_cnt;
   assign mem_req.line  = pf_base + ifp_laddr_t'(pf_cnt); // R9
   assign req_fire      = mem_req_valid && mem_req_ready;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         pc <= IFP_RESET_PC;
      else if (redirect_valid)
         pc <= redirect_pc; // R4
      else if (grp_load)
         pc <= {pc[IFP_ADDR_W-1:IFP_GRP_LSB] + 1'b1, 4'h0}; // R3
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         fstate <= FS_LOOKUP;
      else
      begin
         case (fstate)
            FS_LOOKUP:
               if (take_sec)
                  fstate <= FS_SILO; // R7
            FS_SILO:
               fstate <= FS_LOOKUP;
            default:
               fstate <= FS_LOOKUP;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         silo <= '0;
      else if (want)
         silo <= rdata[~primary]; // R7
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         mode <= MODE_ACCESS;
      else if (redirect_valid)
         mode <= MODE_ACCESS; // R16
      else if (want && (|hit))
         mode <= MODE_ACCESS; // R15
      else if (true_miss)
         mode <= MODE_FILL; // R14
   end

   // Prefetch sequence: demand line first, then following lines
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         pf_active <= 1'b0;
         pf_cnt    <= '0;
         pf_base   <= '0;
      end
      else if (redirect_valid || (want && (|hit)))
         pf_active <= 1'b0; // R15
      else if (true_miss)
      begin
         pf_active <= 1'b1; // R11
         pf_cnt    <= '0;
         pf_base   <= line_of(pc);
      end
      else if (req_fire)
      begin
         pf_cnt <= pf_cnt + 1'b1;
         if (pf_cnt == IFP_RB_ID_W'(IFP_RB_ENTRIES - 1))
            pf_active <= 1'b0; // R9
      end
   end

   // Buffer entries: a new sequence overwrites, returns land only if the
   // entry still waits for that line, so stale returns cannot corrupt it
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int e = 0; e < IFP_RB_ENTRIES; e++)
         begin
            rb_state[e] <= RB_EMPTY;
            rb_line[e]  <= '0;
            rb_used[e]  <= 2'b00;
         end
      end
      else
      begin
         for (int e = 0; e < IFP_RB_ENTRIES; e++)
         begin
            if (req_fire && pf_cnt == IFP_RB_ID_W'(e))
            begin
               rb_state[e] <= RB_PEND; // R10
               rb_line[e]  <= mem_req.line;
               rb_used[e]  <= 2'b00;
            end
            else if (mem_resp_valid && mem_resp.id == IFP_RB_ID_W'(e)
                     && rb_state[e] == RB_PEND && rb_line[e] == mem_resp.line)
               rb_state[e] <= RB_FULL; // R16
            else if (take_rb && rb_sel == IFP_RB_ID_W'(e))
            begin
               rb_used[e][pc[IFP_GRP_LSB]] <= 1'b1;
               if ((rb_used[e] | (2'b01 << pc[IFP_GRP_LSB])) == 2'b11)
                  rb_state[e] <= RB_EMPTY; // R10
            end
         end
      end
   end

   always_ff @(posedge clock)
   begin
      for (int e = 0; e < IFP_RB_ENTRIES; e++)
         if (mem_resp_valid && mem_resp.id == IFP_RB_ID_W'(e)
             && rb_state[e] == RB_PEND && rb_line[e] == mem_resp.line)
            rb_data[e] <= mem_resp.data; // R5
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         last_fill_ok  <= 1'b0;
         last_fill_way <= 1'b0;
         last_fill_grp <= '0;
      end
      else if (take_rb)
      begin
         last_fill_ok  <= 1'b1; // R12
         last_fill_way <= fill_way;
         last_fill_grp <= pc[IFP_ADDR_W-1:IFP_GRP_LSB];
      end
   end

endmodule

// >>> rtl/ifp_pkg.sv
package ifp_pkg;

   localparam int IFP_ADDR_W     = 32;
   localparam int IFP_INSTR_W    = 32;
   localparam int IFP_SLOTS      = 4;
   localparam int IFP_GROUP_W    = IFP_SLOTS * IFP_INSTR_W;
   localparam int IFP_LINE_W     = 2 * IFP_GROUP_W;
   localparam int IFP_RB_ENTRIES = 4;
   localparam int IFP_RB_ID_W    = 2;
   localparam int IFP_WAYS       = 2;
   localparam int IFP_SUBBLOCKS  = 4;
   localparam int IFP_IDX_W      = 6;
   localparam int IFP_SETS       = 1 << IFP_IDX_W;

   localparam int IFP_SLOT_LSB   = 2;
   localparam int IFP_GRP_LSB    = 4;
   localparam int IFP_LINE_LSB   = 5;
   localparam int IFP_BLK_LSB    = 6;
   localparam int IFP_TAG_LSB    = IFP_BLK_LSB + IFP_IDX_W;
   localparam int IFP_TAG_W      = IFP_ADDR_W - IFP_TAG_LSB;
   localparam int IFP_LADDR_W    = IFP_ADDR_W - IFP_LINE_LSB;
   localparam int IFP_GADDR_W    = IFP_ADDR_W - IFP_GRP_LSB;

   typedef logic [IFP_ADDR_W-1:0]  ifp_addr_t;
   typedef logic [IFP_GROUP_W-1:0] ifp_group_t;
   typedef logic [IFP_LINE_W-1:0]  ifp_line_t;
   typedef logic [IFP_LADDR_W-1:0] ifp_laddr_t;

   localparam ifp_addr_t IFP_RESET_PC = 32'h0000_0000;

   typedef struct packed {
      logic [IFP_RB_ID_W-1:0] id;
      ifp_laddr_t             line;
   } ifp_mem_req_t;

   typedef struct packed {
      logic [IFP_RB_ID_W-1:0] id;
      ifp_laddr_t             line;
      ifp_line_t              data;
   } ifp_mem_resp_t;

   typedef struct packed {
      logic                   way;
      logic [IFP_IDX_W-1:0]   idx;
      logic [1:0]             sub;
      logic [IFP_TAG_W-1:0]   tag;
      ifp_group_t             data;
   } ifp_cwr_t;

   typedef enum logic [1:0] {RB_EMPTY, RB_PEND, RB_FULL} ifp_rb_state_t;
   typedef enum logic {FS_LOOKUP, FS_SILO} ifp_fetch_state_t;
   typedef enum logic {MODE_ACCESS, MODE_FILL} ifp_mode_t;

endpackage

// >>> rtl/ifp_icache_ways.sv
`timescale 1ns/10ps
module ifp_icache_ways
(
   input  wire logic                                clock,
   input  wire logic                                rstn,
   input  wire ifp_pkg::ifp_addr_t                  rd_addr,
   input  wire logic                                touch_en,
   input  wire logic                                touch_way,
   input  wire logic                                wr_en,
   input  wire ifp_pkg::ifp_cwr_t                   wr,
   output logic [1:0]                               hit,
   output logic                                     primary,
   output ifp_pkg::ifp_group_t                      rdata [2]
);
   import ifp_pkg::*;

   logic [IFP_IDX_W-1:0] idx;
   logic [1:0]           sub;
   logic [IFP_SETS-1:0]  mru;

   assign idx     = rd_addr[IFP_TAG_LSB-1:IFP_BLK_LSB];
   assign sub     = rd_addr[IFP_BLK_LSB-1:IFP_GRP_LSB];
   assign primary = mru[idx]; // R18

   // Most recently used way per index becomes primary for the next fetch
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         mru <= '0;
      else if (touch_en)
         mru[idx] <= touch_way; // R18
   end

   genvar w;
   generate
      for (w = 0; w < IFP_WAYS; w++)
      begin : g_way
         logic [IFP_TAG_W-1:0]     tag_mem  [IFP_SETS];
         logic [IFP_SUBBLOCKS-1:0] vld_mem  [IFP_SETS];
         ifp_group_t               data_mem [IFP_SETS*IFP_SUBBLOCKS];
         logic                     wr_here;

         assign wr_here = wr_en && (wr.way == 1'(w));

         // Both ways compare in the same cycle
         assign hit[w]   = vld_mem[idx][sub]
                           && (tag_mem[idx] == rd_addr[IFP_ADDR_W-1:IFP_TAG_LSB]); // R6
         assign rdata[w] = data_mem[{idx, sub}];

         // One valid bit per 16-byte subblock; a new tag drops the others
         always_ff @(posedge clock or negedge rstn)
         begin
            if (!rstn)
            begin
               for (int s = 0; s < IFP_SETS; s++)
                  vld_mem[s] <= '0;
            end
            else if (wr_here)
            begin
               if (tag_mem[wr.idx] == wr.tag)
                  vld_mem[wr.idx][wr.sub] <= 1'b1; // R17
               else
                  vld_mem[wr.idx] <= 4'h1 << wr.sub; // R17
            end
         end

         always_ff @(posedge clock)
         begin
            if (wr_here)
            begin
               tag_mem[wr.idx]          <= wr.tag;
               data_mem[{wr.idx, wr.sub}] <= wr.data;
            end
         end
      end
   endgenerate

endmodule

// >>> rtl/ifp_issue.sv
`timescale 1ns/10ps
module ifp_issue
(
   input  wire logic                 clock,
   input  wire logic                 rstn,
   input  wire logic                 flush,
   input  wire logic                 load,
   input  wire ifp_pkg::ifp_group_t  load_group,
   input  wire logic [1:0]           load_start,
   input  wire logic [3:0]           slot_ready,
   output logic                      need,
   output logic [3:0]                issue_mask,
   output ifp_pkg::ifp_group_t       issue_group
);
   import ifp_pkg::*;

   logic [3:0] pend;

   assign need = ~|pend; // R3

   // Issue the oldest pending slots whose resources are ready, stopping at
   // the first one that is not, so nothing overtakes a waiting elder
   always_comb
   begin
      logic blocked;
      blocked    = 1'b0;
      issue_mask = 4'h0;
      for (int i = 0; i < IFP_SLOTS; i++)
      begin
         if (pend[i] && !blocked)
         begin
            if (slot_ready[i]) // R1
               issue_mask[i] = 1'b1;
            else
               blocked = 1'b1; // R2
         end
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         pend <= 4'h0;
      else if (flush)
         pend <= 4'h0;
      else if (load && need)
         pend <= 4'hf << load_start; // R4
      else
         pend <= pend & ~issue_mask; // R3
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         issue_group <= '0;
      else if (load && need && !flush)
         issue_group <= load_group;
   end

endmodule

// >>> dv/ifp_fetch_issue_unit_asserts.sv
`timescale 1ns/10ps
module ifp_fetch_issue_unit_chk
(
   input wire logic                   clock,
   input wire logic                   rstn,
   input wire logic                   redirect_valid,
   input wire ifp_pkg::ifp_addr_t     redirect_pc,
   input wire logic [3:0]             slot_ready,
   input wire logic [3:0]             issue_mask,
   input wire ifp_pkg::ifp_group_t    issue_group,
   input wire logic                   mem_req_valid,
   input wire logic                   mem_req_ready,
   input wire ifp_pkg::ifp_mem_req_t  mem_req,
   input wire logic                   mem_resp_valid,
   input wire ifp_pkg::ifp_mem_resp_t mem_resp,
   input wire logic                   fill_mode,
   input wire logic                   way_mispredict
);
   import ifp_pkg::*;
   ifp_group_t prev_group;
   logic       slot3_done;

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   // A group may only be replaced once its last slot went out or a redirect flushed it
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         prev_group <= '0;
         slot3_done <= 1'b1;
      end
      else
      begin
         prev_group <= issue_group;
         if (issue_mask[3] || redirect_valid)
            slot3_done <= 1'b1;
         else if (issue_group != prev_group)
            slot3_done <= 1'b0;
      end
   end

   a_req_hold : assert property (
      mem_req_valid && !mem_req_ready ##1 mem_req_valid |-> $stable(mem_req))
      else $error("request changed before acceptance");
   a_req_fill : assert property (mem_req_valid |-> fill_mode)
      else $error("request outside fill mode");
   a_redir_gate : assert property (redirect_valid |-> !mem_req_valid)
      else $error("request during redirect");
   a_redir_access : assert property (redirect_valid |=> !fill_mode)
      else $error("fill mode kept after redirect");
   a_req_step : assert property (
      mem_req_valid && mem_req_ready && mem_req.id != 2'h3 ##1 mem_req_valid
      |-> mem_req.id == $past(mem_req.id) + 2'h1 && mem_req.line == $past(mem_req.line) + 1'b1)
      else $error("prefetch sequence out of step");
   a_issue_ready : assert property ((issue_mask & ~slot_ready) == 4'h0)
      else $error("issue without resources");
   a_issue_prefix : assert property (
      ((issue_mask + (issue_mask & -issue_mask)) & issue_mask) == 4'h0)
      else $error("issue skipped an older slot");
   a_mispredict_once : assert property (way_mispredict |=> !way_mispredict)
      else $error("way penalty longer than one cycle");
   a_group_advance : assert property (issue_group != prev_group |-> slot3_done)
      else $error("group replaced before fully issued");
endmodule

bind ifp_fetch_issue_unit ifp_fetch_issue_unit_chk ifp_fetch_issue_unit_chk_inst
(
   .clock(clock), .rstn(rstn), .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
   .slot_ready(slot_ready), .issue_mask(issue_mask), .issue_group(issue_group),
   .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req(mem_req),
   .mem_resp_valid(mem_resp_valid), .mem_resp(mem_resp), .fill_mode(fill_mode),
   .way_mispredict(way_mispredict)
);

// >>> dv/ifp_mem_model.sv
`timescale 1ns/10ps
module ifp_mem_model
(
   input  wire logic                  clock,
   input  wire logic                  rstn,
   input  wire logic                  stall,
   input  wire logic                  mem_req_valid,
   output logic                       mem_req_ready,
   input  wire ifp_pkg::ifp_mem_req_t mem_req,
   output logic                       mem_resp_valid,
   output ifp_pkg::ifp_mem_resp_t     mem_resp
);
   import ifp_pkg::*;
   ifp_mem_req_t pend [$];
   int           due [$];
   int           cyc;
   int           j;
   ifp_mem_req_t head;
   ifp_line_t    fill;

   // Replies stay in order; a stalled accept also comes back late
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         cyc = 0;
         pend.delete();
         due.delete();
         mem_req_ready <= 1'b0;
         mem_resp_valid <= 1'b0;
         mem_resp <= '0;
      end
      else
      begin
         cyc = cyc + 1;
         if (mem_req_valid && mem_req_ready)
         begin
            pend.push_back(mem_req);
            due.push_back(cyc + (stall ? 7 : 2));
         end
         mem_req_ready <= !stall;
         if (pend.size() != 0 && due[0] <= cyc)
         begin
            head = pend.pop_front();
            void'(due.pop_front());
            for (j = 0; j < 8; j++)
               fill[32*j +: 32] = ({head.line, 5'h00} + 32'(4 * j)) ^ 32'h5a3c_96e1;
            mem_resp_valid <= 1'b1;
            mem_resp <= {head.id, head.line, fill};
         end
         else
         begin
            mem_resp_valid <= 1'b0;
            // Idle bus must not look like the last fill
            mem_resp <= ~mem_resp;
         end
      end
   end
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import ifp_pkg::*;
   logic          clock, rstn, redirect_valid, stall, full;
   logic          mem_req_valid, mem_req_ready, mem_resp_valid, fill_mode, way_mispredict;
   ifp_addr_t     redirect_pc;
   logic [3:0]    slot_ready, issue_mask;
   ifp_group_t    issue_group;
   ifp_mem_req_t  mem_req;
   ifp_mem_resp_t mem_resp;
   logic [31:0]   exp_q [$];
   logic [31:0]   seed, exp_w;
   int            err_count, compares, issued, reqs, req_snap, mp_cnt, i;

   ifp_fetch_issue_unit ifp_fetch_issue_unit_inst
   (
      .clock(clock), .rstn(rstn), .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
      .slot_ready(slot_ready), .issue_mask(issue_mask), .issue_group(issue_group),
      .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req(mem_req),
      .mem_resp_valid(mem_resp_valid), .mem_resp(mem_resp), .fill_mode(fill_mode),
      .way_mispredict(way_mispredict)
   );
   ifp_mem_model ifp_mem_model_inst
   (
      .clock(clock), .rstn(rstn), .stall(stall), .mem_req_valid(mem_req_valid),
      .mem_req_ready(mem_req_ready), .mem_req(mem_req), .mem_resp_valid(mem_resp_valid),
      .mem_resp(mem_resp)
   );

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task cmp_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task cmp_flag(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task end_sim();
      if (err_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Program order from a new start address, one word per slot
   task fill_exp(input logic [31:0] pc);
      int k;
      exp_q.delete();
      for (k = 0; k < 512; k++)
         exp_q.push_back((pc + 32'(4 * k)) ^ 32'h5a3c_96e1);
   endtask

   task drive();
      logic [31:0] r;
      @(negedge clock);
      r = xs();
      slot_ready = full ? 4'hf : r[3:0];
      stall = r[5] & r[6];
   endtask

   task run_until(input int n, input int lim);
      int c;
      for (c = 0; c < lim && issued < n; c++)
         drive();
   endtask

   // Ready is dropped around the redirect so nothing issues from the flushed group
   task redirect_to(input logic [31:0] pc);
      @(negedge clock);
      slot_ready = 4'h0;
      @(negedge clock);
      redirect_valid = 1'b1;
      redirect_pc = pc;
      fill_exp(pc);
      issued = 0;
      reqs = 0;
      @(negedge clock);
      redirect_valid = 1'b0;
   endtask

   // Looks just before the rising edge, after this cycle's inputs have settled
   always @(negedge clock)
   begin
      #1;
      if (rstn === 1'b1)
      begin
         for (i = 0; i < 4; i++)
         begin
            if (issue_mask[i] === 1'b1)
            begin
               exp_w = exp_q.size() != 0 ? exp_q.pop_front() : 32'hx;
               cmp_word(issue_group[32*i +: 32], exp_w);
               issued++;
               if (issued == 32)
                  req_snap = reqs;
            end
         end
         if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1)
            reqs++;
         if (way_mispredict === 1'b1)
            mp_cnt++;
      end
   end

   initial
   begin
      #100000;
      err_count++;
      end_sim();
   end

   initial
   begin
      int k;
      seed = 32'd37;
      rstn = 1'b0;
      redirect_valid = 1'b0;
      redirect_pc = '0;
      slot_ready = 4'h0;
      stall = 1'b0;
      full = 1'b0;
      err_count = 0;
      compares = 0;
      issued = 0;
      reqs = 0;
      req_snap = 0;
      mp_cnt = 0;
      fill_exp(32'h0);
      repeat (6) @(posedge clock);
      @(negedge clock);
      rstn = 1'b1;
      run_until(200, 3000);
      cmp_flag(issued >= 200, 1'b1);
      redirect_to(32'h4000);
      run_until(40, 2000);
      cmp_word(req_snap, 32'h4);
      for (k = 0; k < 8; k++)
      begin
         // Two streams in different sets, so revisits find their own fills
         redirect_to(32'((k % 2) * 'h800 + (k % 4) * 4));
         run_until(24, 800);
         cmp_flag(issued >= 24, 1'b1);
      end
      cmp_flag(mp_cnt != 0, 1'b1);
      full = 1'b1;
      redirect_to(32'h800);
      run_until(1000, 6);
      cmp_flag(fill_mode, 1'b0);
      cmp_flag(mem_req_valid, 1'b0);
      end_sim();
   end
endmodule
